// ==== hw/hwtd_pkg.sv ====
// package: register map, field layout and types of the wake threshold block
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package hwtd_pkg;

    localparam int DW = 8;
    localparam int AW = 5;
    localparam int VW = 12;
    localparam int NCH = 3;
    localparam int NTHR = 9;

    // register offsets
    localparam logic [AW-1:0] ADDR_X_HI = 5'h00;
    localparam logic [AW-1:0] ADDR_Y_HI = 5'h01;
    localparam logic [AW-1:0] ADDR_Z_HI = 5'h02;
    localparam logic [AW-1:0] ADDR_T_HI = 5'h03;
    localparam logic [AW-1:0] ADDR_NIB_XY = 5'h04;
    localparam logic [AW-1:0] ADDR_NIB_ZT = 5'h05;
    localparam logic [AW-1:0] ADDR_DIAG = 5'h06;
    localparam logic [AW-1:0] ADDR_THR_FIRST = 5'h07;
    localparam logic [AW-1:0] ADDR_THR_LAST = 5'h0F;
    localparam logic [AW-1:0] ADDR_CFG = 5'h10;
    localparam logic [AW-1:0] ADDR_MODE = 5'h11;
    localparam logic [AW-1:0] ADDR_BUS_ADR = 5'h12;
    localparam logic [AW-1:0] ADDR_IRQ_STAT = 5'h13;
    localparam logic [AW-1:0] ADDR_IRQ_MASK = 5'h14;

    // threshold register index inside the threshold block
    localparam int TI_XL = 0;
    localparam int TI_XH = 1;
    localparam int TI_YL = 2;
    localparam int TI_YH = 3;
    localparam int TI_ZL = 4;
    localparam int TI_ZH = 5;
    localparam int TI_XS = 6;
    localparam int TI_YS = 7;
    localparam int TI_ZS = 8;

    // low threshold bits in the shared registers
    localparam int SH_HI_MSB = 5;
    localparam int SH_HI_LSB = 3;
    localparam int SH_LO_MSB = 2;
    localparam int SH_LO_LSB = 0;
    localparam int SH_ANG_LO_MSB = 3;
    localparam int SH_ANG_LO_LSB = 1;

    // config and mode register fields
    localparam int CFG_WAKE = 0;
    localparam int CFG_PAR = 7;
    localparam int MODE_TEMP_DIS = 0;
    localparam int MODE_ANG = 1;
    localparam int MODE_TST_LSB = 2;
    localparam int MODE_PH_LSB = 4;
    localparam int MODE_PAR = 7;

    // diagnostic register fields
    localparam int DIAG_BUS_PAR = 7;
    localparam int DIAG_CFG_ERR = 6;
    localparam int DIAG_MODE_ERR = 5;
    localparam int DIAG_TEST = 4;
    localparam int DIAG_SUPPLY = 3;
    localparam int DIAG_DONE = 2;
    localparam int FRMW = 2;
    localparam int ADRW = 2;

    // interrupt status bits
    localparam int IRQW = 3;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_CONV = 1;
    localparam int IRQ_PERR = 2;

    // reset values give odd parity over all-zero contents
    localparam logic [DW-1:0] CFG_RST = 8'h80;
    localparam logic [DW-1:0] MODE_RST = 8'h80;
    localparam logic [DW-1:0] THR_RST = 8'h00;
    localparam logic [VW-1:0] SAT_BASE = 12'hFF0;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        HWTD_TST_NONE,
        HWTD_TST_VHALL,
        HWTD_TST_SPIN,
        HWTD_TST_SAT
    } hwtd_test_t;

    typedef struct packed {
        logic [VW-1:0] x;
        logic [VW-1:0] y;
        logic [VW-1:0] z;
        logic [VW-1:0] t;
    } hwtd_sample_t;

endpackage

// ==== hw/hwtd_core.sv ====
// module: wake threshold compare, diagnostics and register file
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module hwtd_core
    import hwtd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata,
    // front end, asynchronous to sys_clk
    input wire logic convClk,
    input wire hwtd_sample_t sampleIn,
    input wire logic supplyOkIn,
    input wire logic [ADRW-1:0] addrStrap,
    // front end control
    output logic [1:0] afeTestSel,
    output logic [1:0] afePhase,
    output logic afeVoltTest,
    // events
    output logic wakePulse,
    output logic irq
);

    //--------------------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------------------
    logic linkSync1, linkSync2, linkPrev;
    logic supSync1, supSync2;
    hwtd_sample_t smpSync1, smpSync2;
    logic [ADRW-1:0] strapSync1, strapSync2;
    logic convStart, convEnd, convEndD1;

    // two stages before any logic reads a pin
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            linkSync1 <= 1'b0;
            linkSync2 <= 1'b0;
            linkPrev <= 1'b0;
            supSync1 <= 1'b0;
            supSync2 <= 1'b0;
            smpSync1 <= '0;
            smpSync2 <= '0;
            strapSync1 <= '0;
            strapSync2 <= '0;
        end
        else
        begin
            linkSync1 <= convClk;
            linkSync2 <= linkSync1;
            linkPrev <= linkSync2;
            supSync1 <= supplyOkIn;
            supSync2 <= supSync1;
            smpSync1 <= sampleIn;
            smpSync2 <= smpSync1;
            strapSync1 <= addrStrap;
            strapSync2 <= strapSync1;
        end
    end

    // high phase of the link clock is the conversion in progress
    assign convStart = linkSync2 & ~linkPrev;
    assign convEnd = ~linkSync2 & linkPrev;

    //--------------------------------------------------------------------
    // software registers
    //--------------------------------------------------------------------
    logic [DW-1:0] thrReg [0:NTHR-1];
    logic [DW-1:0] cfgReg;
    logic [DW-1:0] modeReg;
    logic [IRQW-1:0] irqStat;
    logic [IRQW-1:0] irqMask;
    logic wakeArmed;
    logic thrHit;
    logic [3:0] thrIdx;

    assign thrHit = wr && (addr >= ADDR_THR_FIRST) && (addr <= ADDR_THR_LAST);
    assign thrIdx = 4'(addr - ADDR_THR_FIRST);

    // threshold registers keep bits 11..1; bit 0 is added at compare
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NTHR; i++)
                thrReg[i] <= THR_RST;
        end
        else if (thrHit)
        begin
            thrReg[thrIdx] <= wdata;
        end
    end

    // only a write that changes a threshold arms the wake logic
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            wakeArmed <= 1'b0;
        else if (thrHit && (wdata != thrReg[thrIdx]))
            wakeArmed <= 1'b1;
    end

    // config and mode registers
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfgReg <= CFG_RST;
            modeReg <= MODE_RST;
            irqMask <= '0;
        end
        else if (wr)
        begin
            if (addr == ADDR_CFG)
                cfgReg <= wdata;
            if (addr == ADDR_MODE)
                modeReg <= wdata;
            if (addr == ADDR_IRQ_MASK)
                irqMask <= wdata[IRQW-1:0];
        end
    end

    //--------------------------------------------------------------------
    // test selection
    //--------------------------------------------------------------------
    hwtd_test_t testSel;
    logic [1:0] phaseSel;
    logic testActive;
    logic angular;

    // a test runs only while software selects one
    assign testSel = hwtd_test_t'(modeReg[MODE_TST_LSB +: 2]);
    assign phaseSel = modeReg[MODE_PH_LSB +: 2];
    assign testActive = (testSel != HWTD_TST_NONE);
    assign angular = modeReg[MODE_ANG] & modeReg[MODE_TEMP_DIS];

    // front end steering, registered so the pins never glitch
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            afeTestSel <= 2'h0;
            afePhase <= 2'h0;
            afeVoltTest <= 1'b0;
        end
        else
        begin
            afeTestSel <= testSel;
            afePhase <= phaseSel;
            afeVoltTest <= (testSel == HWTD_TST_VHALL);
        end
    end

    //--------------------------------------------------------------------
    // conversion results and status flags
    //--------------------------------------------------------------------
    hwtd_sample_t data;
    logic supplyOk;
    logic convDone;
    logic [FRMW-1:0] frameCnt;

    // results latch at the end of a conversion; sat test loads a pattern
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            data <= '0;
        else if (convEnd)
        begin
            case (testSel)
                HWTD_TST_SAT:
                begin
                    data.x <= SAT_BASE | VW'(phaseSel);
                    data.y <= SAT_BASE | VW'(phaseSel);
                    data.z <= SAT_BASE | VW'(phaseSel);
                    data.t <= SAT_BASE | VW'(phaseSel);
                end
                HWTD_TST_VHALL, HWTD_TST_SPIN:
                    data <= smpSync2;
                default:
                begin
                    data.x <= smpSync2.x;
                    data.y <= smpSync2.y;
                    data.z <= smpSync2.z;
                    // a disabled temperature channel keeps its last value
                    if (!modeReg[MODE_TEMP_DIS])
                        data.t <= smpSync2.t;
                end
            endcase
        end
    end

    // done clears at start, sets at end; supply sampled over the run
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            convDone <= 1'b0;
            supplyOk <= 1'b0;
        end
        else if (convStart)
        begin
            convDone <= 1'b0;
            supplyOk <= supSync2;
        end
        else if (convEnd)
        begin
            convDone <= 1'b1;
            supplyOk <= supplyOk & supSync2;
        end
        else if (linkSync2)
        begin
            supplyOk <= supplyOk & supSync2;
        end
    end

    // frame counter wraps at its field width
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            frameCnt <= '0;
        else if (convEnd)
            frameCnt <= frameCnt + 1'b1;
    end

    //--------------------------------------------------------------------
    // bus address readback
    //--------------------------------------------------------------------
    logic [ADRW-1:0] busAddr;
    logic [1:0] strapCnt;

    // strap caught once the synchroniser has settled after reset
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strapCnt <= 2'h0;
            busAddr <= '0;
        end
        else if (strapCnt != STRAP_SETTLE)
        begin
            strapCnt <= strapCnt + 1'b1;
            busAddr <= strapSync2;
        end
    end

    //--------------------------------------------------------------------
    // parity
    //--------------------------------------------------------------------
    logic modeParErr, cfgParErr, busPar;
    logic [DW-1:0] thrXor;

    always_comb
    begin
        thrXor = cfgReg;
        for (int i = 0; i < NTHR; i++)
            thrXor = thrXor ^ thrReg[i];
    end

    // odd parity: the stored parity bits make the xor one
    assign modeParErr = ~(^modeReg);
    assign cfgParErr = ~(^thrXor);
    assign busPar = ~(^{data, frameCnt});

    //--------------------------------------------------------------------
    // wake threshold compare
    //--------------------------------------------------------------------
    logic [VW-1:0] chVal [0:NCH-1];
    logic [VW-1:0] chLo [0:NCH-1];
    logic [VW-1:0] chHi [0:NCH-1];
    logic [NCH-1:0] outside;
    logic wakeActive;

    // bit 0 of each threshold forced to zero
    assign chLo[0] = {thrReg[TI_XL], thrReg[TI_XS][SH_LO_MSB:SH_LO_LSB], 1'b0};
    assign chHi[0] = {thrReg[TI_XH], thrReg[TI_XS][SH_HI_MSB:SH_HI_LSB], 1'b0};
    assign chLo[2] = {thrReg[TI_ZL], thrReg[TI_ZS][SH_LO_MSB:SH_LO_LSB], 1'b0};
    assign chHi[2] = {thrReg[TI_ZH], thrReg[TI_ZS][SH_HI_MSB:SH_HI_LSB], 1'b0};

    // angular mode borrows the axis3 registers for axis2
    assign chLo[1] = angular ?
        {thrReg[TI_ZL], thrReg[TI_ZS][SH_ANG_LO_MSB:SH_ANG_LO_LSB], 1'b0} :
        {thrReg[TI_YL], thrReg[TI_YS][SH_LO_MSB:SH_LO_LSB], 1'b0};
    assign chHi[1] = angular ?
        {thrReg[TI_ZH], thrReg[TI_ZS][SH_HI_MSB:SH_HI_LSB], 1'b0} :
        {thrReg[TI_YH], thrReg[TI_YS][SH_HI_MSB:SH_HI_LSB], 1'b0};

    assign chVal[0] = data.x;
    assign chVal[1] = data.y;
    assign chVal[2] = data.z;

    // inside the window, bounds included, no event is raised
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++)
        begin : g_win
            assign outside[gc] = (chVal[gc] > chHi[gc]) || (chVal[gc] < chLo[gc]);
        end
    endgenerate

    // wrong window order is the host's fault and gives constant events
    assign wakeActive = cfgReg[CFG_WAKE] & wakeArmed;

    // compare one cycle after the results have latched
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            convEndD1 <= 1'b0;
            wakePulse <= 1'b0;
        end
        else
        begin
            convEndD1 <= convEnd;
            wakePulse <= convEndD1 & wakeActive & (|outside);
        end
    end

    //--------------------------------------------------------------------
    // interrupt status
    //--------------------------------------------------------------------
    logic [IRQW-1:0] irqSet, irqClr;
    logic parErrPrev;

    assign irqSet[IRQ_WAKE] = wakePulse;
    assign irqSet[IRQ_CONV] = convEndD1;
    assign irqSet[IRQ_PERR] = (modeParErr | cfgParErr) & ~parErrPrev;
    assign irqClr = (wr && addr == ADDR_IRQ_STAT) ? wdata[IRQW-1:0] : '0;

    // a set in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irqStat <= '0;
            parErrPrev <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            irqStat <= (irqStat & ~irqClr) | irqSet;
            parErrPrev <= modeParErr | cfgParErr;
            irq <= |(irqStat & irqMask);
        end
    end

    //--------------------------------------------------------------------
    // read port
    //--------------------------------------------------------------------
    logic [DW-1:0] next_rdata;
    logic [DW-1:0] diag;

    always_comb
    begin
        diag = '0;
        diag[DIAG_BUS_PAR] = busPar;
        diag[DIAG_CFG_ERR] = cfgParErr;
        diag[DIAG_MODE_ERR] = modeParErr;
        diag[DIAG_TEST] = testActive;
        diag[DIAG_SUPPLY] = supplyOk;
        diag[DIAG_DONE] = convDone;
        diag[FRMW-1:0] = frameCnt;
    end

    // unmapped offsets read as zero
    always_comb
    begin
        next_rdata = '0;
        if (addr >= ADDR_THR_FIRST && addr <= ADDR_THR_LAST)
            next_rdata = thrReg[thrIdx];
        else
        begin
            case (addr)
                ADDR_X_HI: next_rdata = data.x[VW-1:4];
                ADDR_Y_HI: next_rdata = data.y[VW-1:4];
                ADDR_Z_HI: next_rdata = data.z[VW-1:4];
                ADDR_T_HI: next_rdata = data.t[VW-1:4];
                ADDR_NIB_XY: next_rdata = {data.x[3:0], data.y[3:0]};
                ADDR_NIB_ZT: next_rdata = {data.z[3:0], data.t[3:2], 2'h0};
                ADDR_DIAG: next_rdata = diag;
                ADDR_CFG: next_rdata = cfgReg;
                ADDR_MODE: next_rdata = modeReg;
                ADDR_BUS_ADR: next_rdata = {{(DW-ADRW){1'b0}}, busAddr};
                ADDR_IRQ_STAT: next_rdata = {{(DW-IRQW){1'b0}}, irqStat};
                ADDR_IRQ_MASK: next_rdata = {{(DW-IRQW){1'b0}}, irqMask};
                default: next_rdata = '0;
            endcase
        end
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= '0;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= '0;
    end

endmodule // hwtd_core

// ==== tb/hwtd_core_chk.sv ====
// checker: port-level timing relations
`timescale 1ns/1ps
module hwtd_core_chk
    import hwtd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input wire logic wr,
    input wire logic rd,
    input wire logic [DW-1:0] rdata,
    // front end and events
    input wire logic convClk,
    input wire logic [1:0] afeTestSel,
    input wire logic [1:0] afePhase,
    input wire logic afeVoltTest,
    input wire logic wakePulse,
    input wire logic irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    //------------------------------------------------------------
    // helper: cycles since the link clock was seen falling
    //------------------------------------------------------------
    logic convQ;
    logic [3:0] sinceFall;
    // saturates so a stalled link never wraps back into the window
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            convQ <= 1'b0;
            sinceFall <= 4'hF;
        end
        else
        begin
            convQ <= convClk;
            if (convQ && !convClk)
                sinceFall <= 4'h0;
            else if (sinceFall != 4'hF)
                sinceFall <= sinceFall + 4'h1;
        end
    end
    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    a_wake_timing: assert property (wakePulse |-> sinceFall inside {[4'h2:4'h5]})
        else $error("wake pulse not tied to a conversion end");
    a_pulse_single: assert property (wakePulse |=> !wakePulse)
        else $error("wake pulse longer than one cycle");
    a_volt_mode: assert property (afeVoltTest == (afeTestSel == 2'h1))
        else $error("voltage test flag disagrees with test select");
    a_test_source: assert property ($changed(afeTestSel) |-> $past(wr) || $past(wr, 2))
        else $error("test select changed without a write");
    a_phase_source: assert property ($changed(afePhase) |-> $past(wr) || $past(wr, 2))
        else $error("phase select changed without a write");
    a_irq_drop: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt dropped without a write");
    a_reset_quiet: assert property ($rose(nrst) |-> !wakePulse && !irq && rdata == 8'h00)
        else $error("outputs active right after reset");
    // main scenarios
    c_wake: cover property (wakePulse);
    c_irq: cover property ($rose(irq));
    c_sat: cover property (afeTestSel == 2'h3);
endmodule // hwtd_core_chk

// ==== tb/hwtd_afe_model.sv ====
// model: front end running conversions
`timescale 1ns/1ps
module hwtd_afe_model
    import hwtd_pkg::*;
#(
    parameter logic [VW-1:0] VH_X = 12'h276,
    parameter logic [VW-1:0] VH_Y = 12'h276,
    parameter logic [VW-1:0] VH_Z = 12'h33E,
    parameter logic [VW-1:0] VEXT = 12'h55A
)
(
    // control from the bench and the design
    input wire logic run,
    input wire logic sag,
    input wire hwtd_sample_t field,
    input wire logic [1:0] testSel,
    // link toward the design
    output logic convClk,
    output hwtd_sample_t sample,
    output logic supplyOk
);
    // supply dips only inside a running conversion
    assign supplyOk = !(sag && convClk);
    // free 800 ns frame grid; clock stands low when no conversion is asked
    // data is junk early in a frame, so a latch taken too soon shows up
    initial
    begin
        convClk = 1'b0;
        sample = '0;
        #37;
        forever
        begin
            convClk = run;
            sample = ~sample;
            #200;
            if (convClk && testSel == 2'h1)
                sample = {VH_X, VH_Y, VH_Z, VEXT};
            else
                sample = field;
            #200;
            convClk = 1'b0;
            #400;
        end
    end
endmodule // hwtd_afe_model

// ==== tb/test_hall_wake_threshold_diag.sv ====
// bench: scenarios of the wake threshold block
`timescale 1ns/1ps
module test_hall_wake_threshold_diag
    import hwtd_pkg::*;
;
    localparam logic [VW-1:0] VH_X = 12'h276;
    localparam logic [VW-1:0] VEXT = 12'h55A;
    logic sys_clk;
    logic nrst;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
    logic [DW-1:0] rdata;
    logic convClk;
    hwtd_sample_t sampleIn;
    hwtd_sample_t field;
    logic supplyOk;
    logic [ADRW-1:0] addrStrap;
    logic [1:0] afeTestSel;
    logic [1:0] afePhase;
    logic afeVoltTest;
    logic wakePulse;
    logic irq;
    logic run;
    logic sag;
    logic [1:0] ph;
    logic rdPend = 1'b0;
    int nWake = 0;
    int c0;
    int n_mismatch = 0;
    int checks = 0;
    logic [DW-1:0] thr [NTHR];
    logic [VW-1:0] v [NCH];
    logic [DW-1:0] expQ [$];
    logic [DW-1:0] mskQ [$];
    //------------------------------------------------------------
    // design, front end and clock
    //------------------------------------------------------------
    hwtd_core dut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .convClk(convClk), .sampleIn(sampleIn),
        .supplyOkIn(supplyOk), .addrStrap(addrStrap), .afeTestSel(afeTestSel),
        .afePhase(afePhase), .afeVoltTest(afeVoltTest), .wakePulse(wakePulse), .irq(irq));
    hwtd_afe_model #(.VH_X(VH_X), .VEXT(VEXT)) model (.run(run), .sag(sag), .field(field),
        .testSel(afeTestSel), .convClk(convClk), .sample(sampleIn), .supplyOk(supplyOk));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    //------------------------------------------------------------
    // host tasks
    //------------------------------------------------------------
    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
    endtask
    // the expected value is noted before the strobe goes out
    task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge sys_clk);
    endtask
    task automatic idle(input int n);
        rd <= 1'b0;
        wr <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    // outputs are looked at mid-cycle, clear of the launching edge
    task automatic chk_irq(input logic e);
        idle(2);
        @(negedge sys_clk);
        check({7'h00, irq}, {7'h00, e});
        @(posedge sys_clk);
    endtask
    task automatic set_thr(input int i, input logic [DW-1:0] val);
        thr[i] = val;
        wr_reg(ADDR_THR_FIRST + AW'(i), val);
    endtask
    task automatic set_win(input int i, input logic [VW-1:0] lo, input logic [VW-1:0] hi);
        set_thr(2 * i, lo[11:4]);
        set_thr(2 * i + 1, hi[11:4]);
        set_thr(TI_XS + i, {2'h0, hi[3:1], lo[3:1]});
    endtask
    // config parity spans the threshold block, so rewrite after any change
    task automatic set_cfg(input logic wake);
        logic p;
        p = wake;
        foreach (thr[k]) p = p ^ (^thr[k]);
        wr_reg(ADDR_CFG, {~p, 6'h00, wake});
    endtask
    task automatic set_mode(input logic [1:0] tst, input logic [1:0] phs, input logic ang);
        logic [6:0] m;
        m = {1'b0, phs, tst, ang, ang};
        wr_reg(ADDR_MODE, {~^m, m});
    endtask
    task automatic conv(input int n, input logic [DW-1:0] w);
        idle(1);
        c0 = nWake;
        run <= 1'b1;
        repeat (n) @(negedge convClk);
        run <= 1'b0;
        @(posedge sys_clk);
        idle(8);
        @(negedge sys_clk);
        check(8'(nWake - c0), w);
        @(posedge sys_clk);
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // read answers and wake pulses are collected at each edge
    always @(posedge sys_clk)
    begin
        rdPend <= rd;
        if (rdPend === 1'b1)
            check(rdata & mskQ.pop_front(), expQ.pop_front());
        if (wakePulse === 1'b1)
            nWake <= nWake + 1;
    end
    // a hang ends the run as a failure
    initial
    begin
        #1000000;
        n_mismatch++;
        test_done();
    end
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        {addr, wdata, wr, rd, run, sag, addrStrap} = '0;
        field = '0;
        foreach (thr[k]) thr[k] = THR_RST;
        void'($urandom(32'h2894));
        addrStrap = 2'($urandom);
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        idle(4);
        rd_reg(ADDR_CFG, CFG_RST, 8'hFF);
        rd_reg(ADDR_MODE, MODE_RST, 8'hFF);
        for (int a = 7; a <= 15; a++) rd_reg(AW'(a), THR_RST, 8'hFF);
        rd_reg(ADDR_IRQ_MASK, 8'h00, 8'hFF);
        rd_reg(ADDR_IRQ_STAT, 8'h00, 8'hFF);
        wr_reg(ADDR_BUS_ADR, {6'h00, ~addrStrap});
        wr_reg(5'h1F, 8'hFF);
        rd_reg(ADDR_BUS_ADR, {6'h00, addrStrap}, 8'h03);
        rd_reg(5'h1F, 8'h00, 8'hFF);
        rd_reg(ADDR_DIAG, 8'h00, 8'h13);
        $display("reset values done");
        field = hwtd_sample_t'(48'({$urandom(), $urandom()}));
        conv(5, 8'h00);
        rd_reg(ADDR_DIAG, {~^{field, 2'h1}, 7'h0D}, 8'h9F);
        rd_reg(ADDR_X_HI, field.x[11:4], 8'hFF);
        rd_reg(ADDR_NIB_XY, {field.x[3:0], field.y[3:0]}, 8'hFF);
        sag <= 1'b1;
        conv(3, 8'h00);
        sag <= 1'b0;
        rd_reg(ADDR_DIAG, 8'h04, 8'h1F);
        $display("conversions done");
        set_cfg(1'b1);
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        field.x = 12'h800;
        set_thr(TI_XL, THR_RST);
        conv(2, 8'h00);
        foreach (v[i])
        begin
            v[i] = (12'h200 + 12'($urandom % 2560)) & 12'hFFE;
            set_win(i, v[i] - 12'h40, v[i] + 12'h40);
        end
        set_cfg(1'b1);
        field = {v[0] + 12'h40, v[1] - 12'h40, v[2], 12'h400};
        conv(3, 8'h00);
        rd_reg(ADDR_DIAG, 8'h00, 8'h60);
        field.x = v[0] + 12'h41;
        conv(2, 8'h02);
        chk_irq(1'b1);
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        chk_irq(1'b0);
        rd_reg(ADDR_IRQ_STAT, 8'h03, 8'h03);
        wr_reg(ADDR_IRQ_STAT, 8'h07);
        wr_reg(ADDR_IRQ_MASK, 8'h03);
        chk_irq(1'b0);
        set_win(0, field.x - 12'h40, field.x + 12'h40);
        $display("wake window done");
        set_mode(HWTD_TST_NONE, 2'h0, 1'b1);
        set_win(1, 12'h010, 12'h020);
        set_win(2, 12'h4F0, 12'h510);
        set_cfg(1'b1);
        field = {v[0], 12'h500, 12'h500, 12'h400};
        conv(2, 8'h00);
        field.y = 12'h520;
        conv(2, 8'h02);
        $display("angular window done");
        nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        foreach (thr[k]) thr[k] = THR_RST;
        set_mode(HWTD_TST_NONE, 2'h0, 1'b0);
        set_cfg(1'b0);
        for (int t = 1; t < 4; t++)
        begin
            ph = 2'($urandom);
            set_mode(2'(t), ph, 1'b0);
            idle(3);
            @(negedge sys_clk);
            check({1'b0, afeVoltTest, afePhase, 2'h0, afeTestSel}, {1'b0, t == 1, ph, 4'(t)});
            @(posedge sys_clk);
            conv(1, 8'h00);
            rd_reg(ADDR_DIAG, 8'h10, 8'h10);
            if (t == 1)
                rd_reg(ADDR_X_HI, VH_X[11:4], 8'hFF);
            if (t == 1)
                rd_reg(ADDR_T_HI, VEXT[11:4], 8'hFF);
            if (t == 3)
                rd_reg(ADDR_NIB_XY, {2'h0, ph, 2'h0, ph}, 8'hFF);
        end
        set_mode(HWTD_TST_NONE, 2'h0, 1'b0);
        conv(1, 8'h00);
        rd_reg(ADDR_DIAG, 8'h00, 8'h10);
        idle(2);
        $display("test modes done");
        test_done();
    end
endmodule // test_hall_wake_threshold_diag

bind hwtd_core hwtd_core_chk chk (.sys_clk(sys_clk), .nrst(nrst), .wr(wr), .rd(rd),
    .rdata(rdata), .convClk(convClk), .afeTestSel(afeTestSel), .afePhase(afePhase),
    .afeVoltTest(afeVoltTest), .wakePulse(wakePulse), .irq(irq));
